// *** gp_map.svh ***
/*
 Register offsets, field positions, reset values and vector bases of the
 eight-pin general purpose port. Assumes a 32-bit AXI4-Lite register bus.
*/
`ifndef GP_MAP_SVH
`define GP_MAP_SVH

// ==========================================================
// Register byte offsets
`define GP_DIR       8'h00
`define GP_DIRSET    8'h04
`define GP_DIRCLR    8'h08
`define GP_DIRTGL    8'h0C
`define GP_OUT       8'h10
`define GP_OUTSET    8'h14
`define GP_OUTCLR    8'h18
`define GP_OUTTGL    8'h1C
`define GP_IN        8'h20
`define GP_CTRL      8'h24
`define GP_MASK0     8'h28
`define GP_MASK1     8'h2C
`define GP_FLAGS     8'h30
`define GP_MPC       8'h34
`define GP_CFGALL    8'h38
`define GP_CFG0      8'h40
`define GP_CFG7      8'h5C

// ==========================================================
// Pin configuration fields
`define GP_CFG_SENSE_LSB 0
`define GP_CFG_OPC_LSB   2
`define GP_CFG_INV_BIT   5

// ==========================================================
// Control fields
`define GP_CTRL_CLKOUT  0
`define GP_CTRL_RTCOUT  1
`define GP_CTRL_EVOUT   2
`define GP_CTRL_EVSEL   3
`define GP_CTRL_REMAP   5
`define GP_CLKOUT_PIN   7
`define GP_EVOUT_PIN    6

// ==========================================================
// Reset values
`define GP_RST_BYTE  8'h00
`define GP_RST_CFG   6'h00
`define GP_RST_CTRL  6'h00

// ==========================================================
// Interrupt vector word addresses
`define GP_VEC_PORT_A 12'h084
`define GP_VEC_PORT_B 12'h044
`define GP_VEC_PORT_C 12'h004
`define GP_INT0_OFS   12'h000
`define GP_INT1_OFS   12'h002

`endif

// *** gp_pkg.sv ***
/*
 Types of the general purpose port: sense and driver encodings and the
 packed state record. Assumes gp_map.svh for numbers.
*/
package gp_pkg;

    typedef enum logic [1:0] {
        GP_SENSE_BOTH = 2'h0,
        GP_SENSE_RISE = 2'h1,
        GP_SENSE_FALL = 2'h2,
        GP_SENSE_LOW  = 2'h3
    } gp_sense_t;

    typedef enum logic [2:0] {
        GP_OPC_TOTEM   = 3'h0,
        GP_OPC_KEEPER  = 3'h1,
        GP_OPC_PDOWN   = 3'h2,
        GP_OPC_PUP     = 3'h3,
        GP_OPC_WOR     = 3'h4,
        GP_OPC_WAND    = 3'h5,
        GP_OPC_WOR_PD  = 3'h6,
        GP_OPC_WAND_PU = 3'h7
    } gp_opc_t;

    typedef struct packed {
        logic inv;
        gp_opc_t opc;
        gp_sense_t sense;
    } gp_cfg_t;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] out;
        gp_cfg_t [7:0] cfg;
        logic [7:0] mask0;
        logic [7:0] mask1;
        logic [7:0] flags;
        logic [7:0] mpc;
        logic [5:0] ctrl;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] prev;
        logic rtc1;
        logic rtc2;
        logic clkdiv;
        logic [7:0] pin_o;
        logic [7:0] pin_oe_n;
        logic [7:0] pin_pu;
        logic [7:0] pin_pd;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } gp_state_t;

endpackage

// *** gp_port.sv ***
/*
 Eight-pin general purpose port with AXI4-Lite registers, per-pin driver,
 pull and inversion setup, edge/level sensing onto two masked interrupts,
 alternate function override and clock/event output.
 Assumes pins and rtc_clk are asynchronous to mclk; alternate function and
 event inputs come from logic on mclk.
*/
// How it works
// - Eight pins 0..7, each set as input or output by its direction bit.
// - Per-pin driver: totem-pole, wired-AND, wired-OR, bus-keeper, inverted I/O.
// - Optional pull-up or pull-down for inputs and wired-OR/AND pins.
// - Bus-keeper weakly pulls toward the last level seen on the pin.
// - Per-pin sense of both edges, rising, falling or low level sets flags.
// - Sensing is clocked when the port clock is enabled, asynchronous otherwise.
// - Asynchronous pin change raises a wake request with no clock running.
// - Inverted I/O inverts the pin value before sensing.
// - Two port interrupts, each with its own per-pin mask.
// - Set, clear and toggle registers change only selected output bits.
// - Direction set/clear/toggle change only selected pins without touching others.
// - One write applies the same configuration to all selected pins.
// - Direction and output registers give single-bit access through the set and clear words.
// - An enabled peripheral may override pin function or output value.
// - Peripheral clock and real-time counter clock can be routed to a pin.
// - Event channels can be driven out on a pin.
// - Peripheral pin locations can be remapped to alternative pins.
// - Interrupt vectors are the port base word address plus interrupt offset.
// - Under reset all pins are tri-stated and registers take initial values.
`timescale 1ns/1ps
`include "gp_map.svh"

module gp_port #(
    parameter int PORT_SEL = 0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_n,
    output logic [7:0] pin_pu,
    output logic [7:0] pin_pd,
    // Alternate functions and system signals
    input wire logic [7:0] alt_en,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    input wire logic [3:0] ev_ch,
    input wire logic rtc_clk,
    input wire logic port_clk_en,
    // Interrupts and wake
    output logic irq0,
    output logic irq1,
    output logic [11:0] irq0_vector,
    output logic [11:0] irq1_vector,
    output logic wake
);

    // Only three vector bases exist
    if (PORT_SEL < 0 || PORT_SEL > 2) begin : g_bad_sel
        $error("PORT_SEL must be 0, 1 or 2");
    end

    // ==========================================================
    // Interrupt vectors
    localparam logic [11:0] VEC_BASE = (PORT_SEL == 0) ? `GP_VEC_PORT_A :
                                       (PORT_SEL == 1) ? `GP_VEC_PORT_B :
                                       `GP_VEC_PORT_C;

    assign irq0_vector = VEC_BASE + `GP_INT0_OFS;
    assign irq1_vector = VEC_BASE + `GP_INT1_OFS;

    gp_pkg::gp_state_t q;
    gp_pkg::gp_state_t d;

    // ==========================================================
    // Bus handshakes
    logic wr_go;
    logic rd_go;

    assign wr_go = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign rd_go = s_axi_arvalid && !q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;

    assign pin_o = q.pin_o;
    assign pin_oe_n = q.pin_oe_n;
    assign pin_pu = q.pin_pu;
    assign pin_pd = q.pin_pd;
    assign irq0 = |(q.flags & q.mask0);
    assign irq1 = |(q.flags & q.mask1);

    // ==========================================================
    // Asynchronous wake
    // Raw pins meet only the last clocked value; no flop of the sync chain
    logic [7:0] raw_inv;
    logic [7:0] async_hit;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            raw_inv[i] = pin_i[i] ^ q.cfg[i].inv;
            case (q.cfg[i].sense)
                gp_pkg::GP_SENSE_RISE: async_hit[i] = raw_inv[i] & ~q.prev[i];
                gp_pkg::GP_SENSE_FALL: async_hit[i] = ~raw_inv[i] & q.prev[i];
                gp_pkg::GP_SENSE_LOW: async_hit[i] = ~raw_inv[i];
                default: async_hit[i] = raw_inv[i] ^ q.prev[i];
            endcase
        end
    end

    assign wake = !port_clk_en && |(async_hit & (q.mask0 | q.mask1));

    // ==========================================================
    // Next state
    always_comb begin
        logic [7:0] cur;
        logic [7:0] hit;
        logic [7:0] wb;
        logic [7:0] val;
        logic [7:0] a_en;
        logic [7:0] a_out;
        logic [7:0] a_oe;
        logic wr_ok;
        logic rd_hit;
        logic [31:0] rd;
        int k;
        cur = '0;
        hit = '0;
        wb = s_axi_wdata[7:0];
        val = '0;
        a_en = '0;
        a_out = '0;
        a_oe = '0;
        wr_ok = 1'b0;
        rd_hit = 1'b1;
        rd = '0;
        k = 0;
        d = q;

        // Pin synchronisers
        d.sync1 = pin_i;
        d.sync2 = q.sync1;
        d.rtc1 = rtc_clk;
        d.rtc2 = q.rtc1;
        d.clkdiv = ~q.clkdiv;

        // Sensing on synchronised, inverted value
        for (int i = 0; i < 8; i++) begin
            cur[i] = q.sync2[i] ^ q.cfg[i].inv;
            case (q.cfg[i].sense)
                gp_pkg::GP_SENSE_BOTH: hit[i] = cur[i] ^ q.prev[i];
                gp_pkg::GP_SENSE_RISE: hit[i] = cur[i] & ~q.prev[i];
                gp_pkg::GP_SENSE_FALL: hit[i] = ~cur[i] & q.prev[i];
                gp_pkg::GP_SENSE_LOW: hit[i] = ~cur[i];
                default: hit[i] = 1'b0;
            endcase
        end
        d.prev = cur;
        if (!port_clk_en) begin
            hit = '0;
        end

        // Register writes
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp = 2'h0;
            wr_ok = s_axi_wstrb[0];
            case (s_axi_awaddr)
                `GP_DIR: if (wr_ok) d.dir = wb;
                `GP_DIRSET: if (wr_ok) d.dir = q.dir | wb;
                `GP_DIRCLR: if (wr_ok) d.dir = q.dir & ~wb;
                `GP_DIRTGL: if (wr_ok) d.dir = q.dir ^ wb;
                `GP_OUT: if (wr_ok) d.out = wb;
                `GP_OUTSET: if (wr_ok) d.out = q.out | wb;
                `GP_OUTCLR: if (wr_ok) d.out = q.out & ~wb;
                `GP_OUTTGL: if (wr_ok) d.out = q.out ^ wb;
                `GP_IN: d.bresp = 2'h0;
                `GP_CTRL: if (wr_ok) d.ctrl = s_axi_wdata[5:0];
                `GP_MASK0: if (wr_ok) d.mask0 = wb;
                `GP_MASK1: if (wr_ok) d.mask1 = wb;
                `GP_FLAGS: if (wr_ok) d.flags = q.flags & ~wb;
                `GP_MPC: if (wr_ok) d.mpc = wb;
                `GP_CFGALL: begin
                    for (int i = 0; i < 8; i++) begin
                        if (wr_ok && q.mpc[i]) begin
                            d.cfg[i] = s_axi_wdata[5:0];
                        end
                    end
                end
                default: begin
                    if (s_axi_awaddr >= `GP_CFG0 && s_axi_awaddr <= `GP_CFG7
                        && s_axi_awaddr[1:0] == 2'h0) begin
                        k = int'(s_axi_awaddr[4:2]);
                        if (wr_ok) d.cfg[k] = s_axi_wdata[5:0];
                    end else begin
                        d.bresp = 2'h2;
                    end
                end
            endcase
        end else if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // New events win over a clear in the same cycle
        d.flags = d.flags | hit;

        // Register reads
        if (rd_go) begin
            case (s_axi_araddr)
                `GP_DIR: rd[7:0] = q.dir;
                `GP_DIRSET: rd[7:0] = q.dir;
                `GP_DIRCLR: rd[7:0] = q.dir;
                `GP_DIRTGL: rd[7:0] = q.dir;
                `GP_OUT: rd[7:0] = q.out;
                `GP_OUTSET: rd[7:0] = q.out;
                `GP_OUTCLR: rd[7:0] = q.out;
                `GP_OUTTGL: rd[7:0] = q.out;
                `GP_IN: rd[7:0] = cur;
                `GP_CTRL: rd[5:0] = q.ctrl;
                `GP_MASK0: rd[7:0] = q.mask0;
                `GP_MASK1: rd[7:0] = q.mask1;
                `GP_FLAGS: rd[7:0] = q.flags;
                `GP_MPC: rd[7:0] = q.mpc;
                `GP_CFGALL: rd = '0;
                default: begin
                    if (s_axi_araddr >= `GP_CFG0 && s_axi_araddr <= `GP_CFG7
                        && s_axi_araddr[1:0] == 2'h0) begin
                        rd[5:0] = q.cfg[s_axi_araddr[4:2]];
                    end else begin
                        rd_hit = 1'b0;
                    end
                end
            endcase
            d.rvalid = 1'b1;
            d.rdata = rd;
            d.rresp = rd_hit ? 2'h0 : 2'h2;
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Alternate functions, nibble swap when remapped
        for (int i = 0; i < 8; i++) begin
            k = q.ctrl[`GP_CTRL_REMAP] ? (i ^ 4) : i;
            a_en[i] = alt_en[k];
            a_out[i] = alt_out[k];
            a_oe[i] = alt_oe[k];
        end
        if (q.ctrl[`GP_CTRL_EVOUT]) begin
            a_en[`GP_EVOUT_PIN] = 1'b1;
            a_oe[`GP_EVOUT_PIN] = 1'b1;
            a_out[`GP_EVOUT_PIN] = ev_ch[q.ctrl[`GP_CTRL_EVSEL +: 2]];
        end
        // Peripheral clock first; only half rate can leave through a flop
        if (q.ctrl[`GP_CTRL_CLKOUT] || q.ctrl[`GP_CTRL_RTCOUT]) begin
            a_en[`GP_CLKOUT_PIN] = 1'b1;
            a_oe[`GP_CLKOUT_PIN] = 1'b1;
            a_out[`GP_CLKOUT_PIN] = q.ctrl[`GP_CTRL_CLKOUT] ? q.clkdiv : q.rtc2;
        end

        // Output driver and pulls
        for (int i = 0; i < 8; i++) begin
            val[i] = q.out[i] ^ q.cfg[i].inv;
            d.pin_o[i] = val[i];
            d.pin_pu[i] = 1'b0;
            d.pin_pd[i] = 1'b0;
            case (q.cfg[i].opc)
                gp_pkg::GP_OPC_WOR, gp_pkg::GP_OPC_WOR_PD: begin
                    d.pin_oe_n[i] = ~(q.dir[i] & val[i]);
                    d.pin_pd[i] = q.cfg[i].opc == gp_pkg::GP_OPC_WOR_PD;
                end
                gp_pkg::GP_OPC_WAND, gp_pkg::GP_OPC_WAND_PU: begin
                    d.pin_oe_n[i] = ~(q.dir[i] & ~val[i]);
                    d.pin_pu[i] = q.cfg[i].opc == gp_pkg::GP_OPC_WAND_PU;
                end
                gp_pkg::GP_OPC_KEEPER: begin
                    d.pin_oe_n[i] = ~q.dir[i];
                    d.pin_pu[i] = q.sync2[i];
                    d.pin_pd[i] = ~q.sync2[i];
                end
                gp_pkg::GP_OPC_PDOWN: begin
                    d.pin_oe_n[i] = ~q.dir[i];
                    d.pin_pd[i] = ~q.dir[i];
                end
                gp_pkg::GP_OPC_PUP: begin
                    d.pin_oe_n[i] = ~q.dir[i];
                    d.pin_pu[i] = ~q.dir[i];
                end
                default: d.pin_oe_n[i] = ~q.dir[i];
            endcase
            if (a_en[i]) begin
                d.pin_o[i] = a_out[i];
                d.pin_oe_n[i] = ~a_oe[i];
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.pin_oe_n <= 8'hFF;
        end else begin
            q <= d;
        end
    end

endmodule

// *** gp_port_chk.sv ***
/*
 Checker of the port's bus handshakes, reset state, pins and vectors.
 Assumes it is bound to gp_port and sees only its ports.
*/
`timescale 1ns/1ps
module gp_port_chk #(
    parameter int PORT_SEL = 0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and side signals
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pu,
    input wire logic [7:0] pin_pd,
    input wire logic [7:0] alt_en,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    input wire logic port_clk_en,
    input wire logic irq0,
    input wire logic wake,
    input wire logic [11:0] irq0_vector,
    input wire logic [11:0] irq1_vector
);
    // ==========================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [11:0] base;
    assign base = PORT_SEL == 1 ? 12'h044 : (PORT_SEL == 2 ? 12'h004 : 12'h084);
    rst_tristate_a:
        assert property ($rose(nrst) |-> pin_oe_n == 8'hFF && (pin_pu | pin_pd) == 8'h00)
        else $error("pins not released after reset");
    wr_answer_a:
        assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write not answered");
    bresp_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    aw_refuse_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    rd_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    rdata_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    vector_base_a:
        assert property (irq0_vector == base && irq1_vector == base + 12'h002)
        else $error("vector mismatch");
    wake_gate_a:
        assert property (port_clk_en |-> !wake)
        else $error("wake while clocked");
    alt_override_a:
        assert property ((alt_en[0] && alt_oe[0] && alt_out[0]) [*3] |-> !pin_oe_n[0] && pin_o[0])
        else $error("alternate function ignored");
    pull_excl_a:
        assert property ((pin_pu & pin_pd) == 8'h00)
        else $error("pull-up and pull-down together");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (irq0);
    cover property (wake);
endmodule

bind gp_port gp_port_chk #(.PORT_SEL(PORT_SEL)) chk_i (.mclk, .nrst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_o,
    .pin_oe_n, .pin_pu, .pin_pd, .alt_en, .alt_out, .alt_oe, .port_clk_en, .irq0, .wake,
    .irq0_vector, .irq1_vector);

// *** gp_board.sv ***
/*
 Board model: resolves each pin from port drive, pulls and board forcing.
 Assumes forcing inputs change after clock edges.
*/
`timescale 1ns/1ps
module gp_board (
    // Clock
    input wire logic mclk,
    // Port drive
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pin_pu,
    input wire logic [7:0] pin_pd,
    // Board forcing
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved level
    output logic [7:0] pin_i
);
    // ==========================================
    // Resolution
    logic [7:0] last_q = 8'h00;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (ext_en[i])
                pin_i[i] = ext_val[i];
            else if (!pin_oe_n[i])
                pin_i[i] = pin_o[i];
            else if (pin_pu[i] | pin_pd[i])
                pin_i[i] = pin_pu[i];
            else
                pin_i[i] = ~last_q[i]; // Floating: never hold the old level
        end
    end
    always @(posedge mclk) last_q <= pin_i;
endmodule

// *** tb_gp_port.sv ***
/*
 Self-checking bench of gp_port over AXI4-Lite with a board model.
 Assumes gp_map.svh offsets and the hand-over timing.
*/
`timescale 1ns/1ps
`include "gp_map.svh"
module tb_gp_port;
    logic mclk, nrst, port_clk_en, rtc_clk, irq0, irq1, wake, e;
    logic [7:0] s_axi_awaddr, s_axi_araddr, pin_i, pin_o, pin_oe_n, pin_pu, pin_pd;
    logic [7:0] alt_en, alt_out, alt_oe, ext_en, ext_val;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, ev_ch;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] irq0_vector, irq1_vector;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    gp_port #(.PORT_SEL(1)) uut (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_i, .pin_o, .pin_oe_n, .pin_pu,
        .pin_pd, .alt_en, .alt_out, .alt_oe, .ev_ch, .rtc_clk, .port_clk_en, .irq0, .irq1,
        .irq0_vector, .irq1_vector, .wake);
    gp_board board (.mclk, .pin_o, .pin_oe_n, .pin_pu, .pin_pd, .ext_en, .ext_val, .pin_i);
    // ==========================================
    // Clock, timeout, helpers
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            $display("[ERR] run exp done got hang");
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("[ERR] %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge mclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_regs();
        rd(8'h7C);
        chk("unmapped", 2'b10, rr);
        wr(`GP_DIRSET, 32'h0F);
        wr(`GP_DIRCLR, 32'h02);
        wr(`GP_DIRTGL, 32'h81);
        rd(`GP_DIR);
        chk("dir", 32'h8C, rv);
        wr(`GP_OUTSET, 32'hFF);
        wr(`GP_OUTCLR, 32'h0F);
        wr(`GP_OUTTGL, 32'h03);
        rd(`GP_OUT);
        chk("out", 32'hF3, rv);
        chk("oe_n", 8'h73, pin_oe_n);
        chk("drive", 8'h80, pin_o & 8'h8C);
        rd(`GP_IN);
        chk("in", 8'h80, rv[7:0] & 8'h8C);
        $display("t_regs done");
    endtask
    task automatic t_cfg();
        wr(`GP_MPC, 32'h30);
        wr(`GP_CFGALL, 32'h0C);
        rd(8'h50);
        chk("cfg4", 32'h0C, rv);
        rd(8'h4C);
        chk("cfg3", 32'h00, rv);
        chk("pullup", 8'h30, pin_pu & 8'h30);
        wr(8'h44, 32'h04);
        ext_en <= 8'h03;
        ext_val <= 8'h02;
        w(6);
        chk("keep_hi", 1, pin_pu[1]);
        ext_val <= 8'h00;
        w(6);
        ext_en <= 8'h01;
        w(6);
        chk("keep_lo", 1, pin_pd[1]);
        wr(8'h48, 32'h1C);
        wr(8'h4C, 32'h30);
        w(2);
        chk("wired_on", 4'b0010, {pin_oe_n[3:2], pin_o[3:2]});
        wr(`GP_OUTSET, 32'h0C);
        w(2);
        chk("wired_off", 4'b1101, {pin_oe_n[3:2], pin_o[3:2]});
        chk("wand_pu", 1, pin_pu[2]);
        $display("t_cfg done");
    endtask
    task automatic t_sense();
        logic [7:0] cfg [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h21};
        logic [4:0] er = 5'b01011;
        logic [4:0] ef = 5'b11101;
        wr(`GP_MASK0, 32'h01);
        for (int i = 0; i < 5; i++) begin
            wr(`GP_CFG0, cfg[i]);
            ext_val <= 8'h00;
            w(6);
            wr(`GP_FLAGS, 32'hFF);
            ext_val <= 8'h01;
            w(6);
            rd(`GP_FLAGS);
            chk("rise", er[i], rv[0]);
            chk("irq0", er[i], irq0);
            wr(`GP_FLAGS, 32'hFF);
            ext_val <= 8'h00;
            w(6);
            rd(`GP_FLAGS);
            chk("fall", ef[i], rv[0]);
        end
        chk("irq1", 0, irq1);
        wr(`GP_MASK1, 32'h01);
        chk("irq1_on", 1, irq1);
        $display("t_sense done");
    endtask
    task automatic t_wake();
        wr(`GP_CFG0, 32'h00);
        wr(`GP_FLAGS, 32'hFF);
        port_clk_en <= 1'b0;
        w(6);
        ext_val <= 8'h01;
        @(negedge mclk);
        chk("wake", 1, wake);
        w(6);
        rd(`GP_FLAGS);
        chk("noflag", 0, rv[0]);
        port_clk_en <= 1'b1;
        $display("t_wake done");
    endtask
    task automatic t_out();
        wr(`GP_DIRSET, 32'hC0);
        ev_ch <= 4'hB;
        wr(`GP_CTRL, 32'h15);
        w(4);
        chk("ev_lo", 0, pin_o[6]);
        ev_ch <= 4'h4;
        w(4);
        chk("ev_hi", 1, pin_o[6]);
        e = pin_o[7];
        w(1);
        chk("clkout", !e, pin_o[7]);
        alt_en <= 8'h01;
        alt_oe <= 8'h01;
        alt_out <= 8'h01;
        w(4);
        chk("alt", 2'b01, {pin_oe_n[0], pin_o[0]});
        alt_en <= 8'h00;
        chk("vec", 24'h044046, {irq0_vector, irq1_vector});
        wr(`GP_CTRL, 32'h22);
        rtc_clk <= 1'b1;
        {alt_en, alt_oe, alt_out} <= {3{8'h10}};
        w(4);
        chk("rtcout", 1, pin_o[7]);
        chk("remap", 2'b01, {pin_oe_n[0], pin_o[0]});
        $display("t_out done");
    endtask
    // ==========================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        port_clk_en = 1'b1;
        rtc_clk = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {alt_en, alt_out, alt_oe, ext_val} = 32'h0;
        ext_en = 8'h01;
        ev_ch = 4'h0;
        repeat (16) @(posedge mclk);
        chk("rst_oe_n", 8'hFF, pin_oe_n);
        chk("rst_pull", 8'h00, pin_pu | pin_pd);
        nrst <= 1'b1;
        t_regs();
        t_cfg();
        t_sense();
        t_wake();
        t_out();
        final_report();
    end
endmodule
